//--- voltage_detect_regs.vh
// Register offsets, field positions, reset values and timing for the voltage detector
`ifndef VOLTAGE_DETECT_REGS_VH
`define VOLTAGE_DETECT_REGS_VH

// Byte addresses of the registers on the AXI4-Lite bus
`define VD_CONTROL_ADDR        8'h00
`define VD_FLAG_ADDR           8'h04
`define VD_ENABLE_ADDR         8'h08
`define VD_PRIORITY_ADDR       8'h0C
`define VD_INTCTL_ADDR         8'h10
`define VD_IRQ_STATUS_ADDR     8'h14
`define VD_IRQ_MASK_ADDR       8'h18

// Control register fields
`define VD_DIR_BIT             7
`define VD_UNUSED_BIT          6
`define VD_STABLE_BIT          5
`define VD_ENABLE_BIT          4
`define VD_LEVEL_MSB           3
`define VD_LEVEL_LSB           0
`define VD_LEVEL_EXTERNAL      4'hF

// Flag, enable and priority position in the second peripheral registers
`define VD_EVENT_BIT           2
// Global enable position in the interrupt control register
`define VD_GLOBAL_BIT          7

// Control reset value: detector off, level 0101
`define VD_CONTROL_RESET       8'h05

// Status / mask bits of the block interrupt register
`define VD_IRQ_EVENT_BIT       0
`define VD_IRQ_STABLE_BIT      1

// Reference settle time in ns and clock period in ns
`define VD_SETTLE_NS           20000
`define VD_CLK_PERIOD_NS       40

`endif

//--- sync_two_flop.v
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none

module sync_two_flop
(
    input  wire clk_i,
    input  wire rst_b_i,
    input  wire async_i,
    output wire sync_o
);

    reg meta_q;
    reg sync_q;

    // First stage feeds only the second stage
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule
`default_nettype wire

//--- settle_timer.v
// Reference settle timer: counts a fixed interval after every enable
`timescale 1ns/100ps
`default_nettype none

module settle_timer
#(
    parameter CYCLES = 500,
    parameter WIDTH  = 16
)
(
    input  wire clk_i,
    input  wire rst_b_i,
    input  wire enable_i,
    output wire stable_o
);

    reg [WIDTH-1:0] count_q;
    reg             stable_q;

    // Restarts from zero whenever the detector is off, so every enable waits again
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            count_q  <= {WIDTH{1'b0}};
            stable_q <= 1'b0;
        end
        else if (!enable_i)
        begin
            count_q  <= {WIDTH{1'b0}};
            stable_q <= 1'b0;
        end
        else if (count_q >= CYCLES[WIDTH-1:0] - 1'b1)
        begin
            stable_q <= 1'b1;
        end
        else
        begin
            count_q <= count_q + 1'b1;
        end
    end

    assign stable_o = stable_q;

endmodule
`default_nettype wire

//--- voltage_detect.v
// Supply voltage detector control, event flag and AXI4-Lite register slave
// Operation
// - Direction bit 1 flags rise to or above trip; 0 flags fall to or below.
// - Control bit 6 is unimplemented and reads zero.
// - Bit 5 reads 1 once the reference is stable, read-only.
// - Enable bit 4 powers the detector on when 1, off when 0.
// - No event after any enable until the reference is stable.
// - Level field bits 3..0 pick one of 16 trip points, 0000 lowest.
// - Level 1111 takes the comparator input from the external trip pin.
// - A crossing in the chosen direction sets the voltage event flag.
// - Flag at bit 2 of flag register, enable bit 2, global enable bit 7.
// - Settle interval is a fixed time, crossings during it may be missed.
// - Detector works in sleep; a crossing sets flag and, with the event enable set, wakes the device.
// - Any reset returns the control register to reset, detector disabled.
`timescale 1ns/100ps
`default_nettype none
`include "voltage_detect_regs.vh"

module voltage_detect
#(
    parameter SETTLE_CYCLES = (`VD_SETTLE_NS + `VD_CLK_PERIOD_NS - 1) / `VD_CLK_PERIOD_NS
)
(
    input  wire        clk_i,
    input  wire        rst_b_i,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Analog comparator side
    input  wire        supply_above_trip_i,
    input  wire        sleep_i,
    output reg         detector_power_o,
    output reg  [3:0]  trip_level_select_o,
    output reg         external_trip_input_sel_o,
    // Interrupt side
    output reg         voltage_irq_o,
    output reg         voltage_irq_priority_o,
    output reg         wake_o,
    output reg         irq_o
);

    localparam [1:0] RESP_OKAY   = 2'b00;
    localparam [1:0] RESP_SLVERR = 2'b10;

    // Reset image of the control register, so each field takes its own bits
    localparam [7:0] CONTROL_RESET = `VD_CONTROL_RESET;

    // Registers
    reg         direction_select_q;
    reg         detector_enable_q;
    reg  [3:0]  trip_level_select_q;
    reg         voltage_event_flag_q;
    reg         voltage_event_irq_enable_q;
    reg         voltage_event_priority_q;
    reg         global_irq_enable_q;
    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_mask_q;
    reg         cross_q;
    reg         stable_q;

    // Bus capture
    reg         aw_held_q;
    reg  [7:0]  aw_addr_q;
    reg         w_held_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;

    wire        compare_sync;
    wire        stable;
    wire        crossing;
    wire        event_set;
    wire        stable_rise;
    wire        wr_fire;
    wire        wr_byte0;
    wire [7:0]  wbyte;
    wire [7:0]  control_view;
    reg  [31:0] rd_data;
    reg         rd_ok;
    reg         wr_ok;

    // Comparator output is asynchronous to the bus clock
    sync_two_flop u_sync
    (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .async_i (supply_above_trip_i),
        .sync_o  (compare_sync)
    );

    // Settle timing comes from a fixed time, not from the detector's clock
    settle_timer #(.CYCLES(SETTLE_CYCLES), .WIDTH(16)) u_settle
    (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .enable_i (detector_enable_q),
        .stable_o (stable)
    );

    // Crossing test: direction 1 takes the comparator's at-or-above-trip level, direction 0 its inverse
    assign crossing  = direction_select_q ? compare_sync : ~compare_sync;
    // Qualified only once stable; sleep does not gate it
    assign event_set = detector_enable_q & stable & crossing & ~cross_q;
    assign stable_rise = stable & ~stable_q;

    // A write fires once both halves are held and the previous answer is gone;
    // holding back on bvalid stops a second write from overtaking an unread response
    assign wr_fire  = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign wr_byte0 = wr_fire & w_strb_q[0];
    assign wbyte    = w_data_q[7:0];

    // Bit 6 forced low, bit 5 is live stability
    assign control_view = {direction_select_q, 1'b0, stable, detector_enable_q,
                           trip_level_select_q};

    // Edge memory: one event per crossing, not one per cycle while beyond trip
    // Limitation: an excursion shorter than one clock may be lost in the synchroniser
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cross_q  <= 1'b0;
            stable_q <= 1'b0;
        end
        else
        begin
            cross_q  <= detector_enable_q & stable & crossing;
            stable_q <= stable;
        end
    end

    // Write address and data are caught separately, in either order
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            aw_held_q     <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_held_q      <= 1'b0;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Address decode for writes
    always @*
    begin
        case (aw_addr_q)
            `VD_CONTROL_ADDR, `VD_FLAG_ADDR, `VD_ENABLE_ADDR, `VD_PRIORITY_ADDR,
            `VD_INTCTL_ADDR, `VD_IRQ_STATUS_ADDR, `VD_IRQ_MASK_ADDR: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // Software-written registers; reset leaves the detector disabled
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            direction_select_q         <= CONTROL_RESET[`VD_DIR_BIT];
            detector_enable_q          <= CONTROL_RESET[`VD_ENABLE_BIT];
            trip_level_select_q        <= CONTROL_RESET[`VD_LEVEL_MSB:`VD_LEVEL_LSB];
            voltage_event_irq_enable_q <= 1'b0;
            voltage_event_priority_q   <= 1'b0;
            global_irq_enable_q        <= 1'b0;
            irq_mask_q                 <= 2'b00;
        end
        else if (wr_byte0)
        begin
            case (aw_addr_q)
                `VD_CONTROL_ADDR:
                begin
                    direction_select_q  <= wbyte[`VD_DIR_BIT];
                    detector_enable_q   <= wbyte[`VD_ENABLE_BIT];
                    trip_level_select_q <= wbyte[`VD_LEVEL_MSB:`VD_LEVEL_LSB];
                end
                `VD_ENABLE_ADDR:   voltage_event_irq_enable_q <= wbyte[`VD_EVENT_BIT];
                `VD_PRIORITY_ADDR: voltage_event_priority_q   <= wbyte[`VD_EVENT_BIT];
                `VD_INTCTL_ADDR:   global_irq_enable_q        <= wbyte[`VD_GLOBAL_BIT];
                `VD_IRQ_MASK_ADDR: irq_mask_q                 <= wbyte[1:0];
                default:           irq_mask_q                 <= irq_mask_q;
            endcase
        end
    end

    // Event flag is sticky; a new event in the clearing cycle wins
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            voltage_event_flag_q <= 1'b0;
        end
        else if (event_set)
        begin
            voltage_event_flag_q <= 1'b1;
        end
        else if (wr_byte0 && aw_addr_q == `VD_FLAG_ADDR && !wbyte[`VD_EVENT_BIT])
        begin
            voltage_event_flag_q <= 1'b0;
        end
    end

    // Block interrupt status: event and stable-reached, write one to clear
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_status_q <= 2'b00;
        end
        else
        begin
            irq_status_q[`VD_IRQ_EVENT_BIT] <= event_set |
                (irq_status_q[`VD_IRQ_EVENT_BIT] & ~(wr_byte0 &
                (aw_addr_q == `VD_IRQ_STATUS_ADDR) & wbyte[`VD_IRQ_EVENT_BIT]));
            irq_status_q[`VD_IRQ_STABLE_BIT] <= stable_rise |
                (irq_status_q[`VD_IRQ_STABLE_BIT] & ~(wr_byte0 &
                (aw_addr_q == `VD_IRQ_STATUS_ADDR) & wbyte[`VD_IRQ_STABLE_BIT]));
        end
    end

    // Read mux
    // Address is used live: the master holds it steady until arready
    always @*
    begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            `VD_CONTROL_ADDR:    rd_data[7:0] = control_view;
            `VD_FLAG_ADDR:       rd_data[`VD_EVENT_BIT] = voltage_event_flag_q;
            `VD_ENABLE_ADDR:     rd_data[`VD_EVENT_BIT] = voltage_event_irq_enable_q;
            `VD_PRIORITY_ADDR:   rd_data[`VD_EVENT_BIT] = voltage_event_priority_q;
            `VD_INTCTL_ADDR:     rd_data[`VD_GLOBAL_BIT] = global_irq_enable_q;
            `VD_IRQ_STATUS_ADDR: rd_data[1:0] = irq_status_q;
            `VD_IRQ_MASK_ADDR:   rd_data[1:0] = irq_mask_q;
            default:             rd_ok = 1'b0;
        endcase
    end

    // Read channel: address taken one cycle, data the next
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Outputs, all registered
    // One cycle of lag is traded for glitch-free levels towards the analog side
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            detector_power_o          <= 1'b0;
            trip_level_select_o       <= 4'h0;
            external_trip_input_sel_o <= 1'b0;
            voltage_irq_o             <= 1'b0;
            voltage_irq_priority_o    <= 1'b0;
            wake_o                    <= 1'b0;
            irq_o                     <= 1'b0;
        end
        else
        begin
            detector_power_o          <= detector_enable_q;
            trip_level_select_o       <= trip_level_select_q;
            external_trip_input_sel_o <= trip_level_select_q == `VD_LEVEL_EXTERNAL;
            // Vectoring needs both the event enable and the global enable
            voltage_irq_o             <= voltage_event_flag_q & voltage_event_irq_enable_q
                                         & global_irq_enable_q;
            voltage_irq_priority_o    <= voltage_event_priority_q;
            // Wake does not depend on the global enable
            wake_o                    <= sleep_i & voltage_event_flag_q
                                         & voltage_event_irq_enable_q;
            irq_o                     <= |(irq_status_q & irq_mask_q);
        end
    end

endmodule
`default_nettype wire

//--- voltage_detect_checker.sv
// Port-level assertions for the supply voltage detector
`timescale 1ns/100ps
`default_nettype none
module voltage_detect_checker
#(
    parameter SETTLE_CYCLES = 4
)
(
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_bvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        sleep_i,
    input wire logic        detector_power_o,
    input wire logic [3:0]  trip_level_select_o,
    input wire logic        external_trip_input_sel_o,
    input wire logic        voltage_irq_o,
    input wire logic        wake_o
);
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Multi-step bus answers as named sequences
    sequence s_write_answer;
        ##[1:8] (s_axi_bvalid && (s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10));
    endsequence
    sequence s_read_answer;
        ##1 s_axi_arready ##1 s_axi_rvalid;
    endsequence
    // Reference still settling: no new event may show on either output
    sequence s_quiet;
        (!$rose(voltage_irq_o) && !$rose(wake_o)) [*3];
    endsequence

    property p_ext_sel;
        external_trip_input_sel_o == (trip_level_select_o == 4'hF);
    endproperty
    property p_wake_sleep;
        wake_o |-> $past(sleep_i);
    endproperty
    property p_reset_off;
        $rose(rst_b_i) |-> !detector_power_o && !voltage_irq_o && !wake_o;
    endproperty
    property p_settle;
        $rose(detector_power_o) |-> s_quiet;
    endproperty
    property p_write_answer;
        $rose(s_axi_awvalid) |-> s_write_answer;
    endproperty
    property p_read_answer;
        $rose(s_axi_arvalid) |-> s_read_answer;
    endproperty
    property p_arready_pulse;
        s_axi_arready |=> !s_axi_arready;
    endproperty
    property p_rdata_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
    endproperty

    a_ext_sel: assert property (p_ext_sel) else $error("external select disagrees with level");
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake without sleep");
    a_reset_off: assert property (p_reset_off) else $error("outputs active after reset");
    a_settle: assert property (p_settle) else $error("event during settle");
    a_write_answer: assert property (p_write_answer) else $error("no write response");
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    a_arready_pulse: assert property (p_arready_pulse) else $error("arready too long");
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
endmodule

bind voltage_detect voltage_detect_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) voltage_detect_checker_i
(
    .clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .sleep_i(sleep_i), .detector_power_o(detector_power_o),
    .trip_level_select_o(trip_level_select_o),
    .external_trip_input_sel_o(external_trip_input_sel_o),
    .voltage_irq_o(voltage_irq_o), .wake_o(wake_o)
);
`default_nettype wire

//--- voltage_detect_test.sv
// Self-checking bench for the supply voltage detector
`timescale 1ns/100ps
`default_nettype none
module voltage_detect_test;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        supply_above_trip_i = 1'b0, sleep_i = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         detector_power_o, external_trip_input_sel_o, voltage_irq_o;
    wire         voltage_irq_priority_o, wake_o, irq_o;
    wire  [3:0]  trip_level_select_o;
    int          num_errors = 0;
    int          tests_run = 0;

    // Short settle count keeps the run brief
    voltage_detect #(.SETTLE_CYCLES(4)) voltage_detect_i
    (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .supply_above_trip_i(supply_above_trip_i),
        .sleep_i(sleep_i), .detector_power_o(detector_power_o),
        .trip_level_select_o(trip_level_select_o),
        .external_trip_input_sel_o(external_trip_input_sel_o),
        .voltage_irq_o(voltage_irq_o), .voltage_irq_priority_o(voltage_irq_priority_o),
        .wake_o(wake_o), .irq_o(irq_o)
    );

    // 25 MHz clock
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic stop_test();
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ckb(input logic got, input logic exp);
        ck({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Each channel is released at the edge that takes it; bready is raised with the valids and held until bvalid
    // No wait limit here: only the watchdog ends a hung transfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        ck({30'h0, s_axi_bresp}, {30'h0, r});
    endtask

    // Read and compare the low byte; upper bytes must read zero
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        ck(s_axi_rdata, {24'h00_0000, e});
        ck({30'h0, s_axi_rresp}, {30'h0, r});
    endtask

    // Main sequence: setup order, crossings both ways, sleep, refusals, reset
    initial
    begin
        wt(6);
        rst_b_i <= 1'b1;
        rd(8'h00, 8'h05, 2'b00);
        wr(8'h00, 8'h60, 2'b00);
        rd(8'h00, 8'h00, 2'b00);
        for (int l = 0; l < 16; l++)
        begin
            wr(8'h00, 8'(l), 2'b00);
            wt(2);
            ck({28'h0, trip_level_select_o}, 32'(l));
            ckb(external_trip_input_sel_o, l == 15);
            rd(8'h00, 8'(l), 2'b00);
        end
        wr(8'h00, 8'h9A, 2'b00);
        wt(1);
        ckb(detector_power_o, 1'b1);
        wt(12);
        rd(8'h00, 8'hBA, 2'b00);
        wr(8'h04, 8'h00, 2'b00);
        wr(8'h08, 8'h04, 2'b00);
        wr(8'h10, 8'h80, 2'b00);
        wr(8'h18, 8'h01, 2'b00);
        wr(8'h14, 8'h03, 2'b00);
        supply_above_trip_i <= 1'b1;
        wt(8);
        ckb(voltage_irq_o, 1'b1);
        ckb(irq_o, 1'b1);
        rd(8'h04, 8'h04, 2'b00);
        rd(8'h14, 8'h01, 2'b00);
        supply_above_trip_i <= 1'b0;
        wt(8);
        rd(8'h04, 8'h04, 2'b00);
        ckb(voltage_irq_o, 1'b1);
        // Mask, unmask, then clear the sticky status
        wr(8'h18, 8'h00, 2'b00);
        wt(3);
        ckb(irq_o, 1'b0);
        wr(8'h18, 8'h01, 2'b00);
        wt(3);
        ckb(irq_o, 1'b1);
        wr(8'h14, 8'h01, 2'b00);
        wt(3);
        ckb(irq_o, 1'b0);
        rd(8'h14, 8'h00, 2'b00);
        wr(8'h04, 8'h04, 2'b00);
        rd(8'h04, 8'h04, 2'b00);
        wr(8'h04, 8'h00, 2'b00);
        rd(8'h04, 8'h00, 2'b00);
        wt(2);
        ckb(voltage_irq_o, 1'b0);
        // Falling direction while asleep, global enable off
        wr(8'h10, 8'h00, 2'b00);
        // Turn direction while off: a still-low supply would count as a fall at once
        wr(8'h00, 8'h0A, 2'b00);
        supply_above_trip_i <= 1'b1;
        wr(8'h00, 8'h1A, 2'b00);
        sleep_i <= 1'b1;
        wt(8);
        rd(8'h04, 8'h00, 2'b00);
        supply_above_trip_i <= 1'b0;
        wt(8);
        ckb(wake_o, 1'b1);
        ckb(voltage_irq_o, 1'b0);
        rd(8'h04, 8'h04, 2'b00);
        sleep_i <= 1'b0;
        wr(8'h0C, 8'h04, 2'b00);
        wt(2);
        ckb(voltage_irq_priority_o, 1'b1);
        rd(8'h0C, 8'h04, 2'b00);
        // Unmapped address is refused both ways
        rd(8'h1C, 8'h00, 2'b10);
        wr(8'h1C, 8'h55, 2'b10);
        wr(8'h00, 8'h0A, 2'b00);
        wt(1);
        ckb(detector_power_o, 1'b0);
        rd(8'h00, 8'h0A, 2'b00);
        // Reset in mid-run with the detector on
        wr(8'h00, 8'h9A, 2'b00);
        rst_b_i <= 1'b0;
        wt(2);
        rst_b_i <= 1'b1;
        wt(1);
        ckb(detector_power_o, 1'b0);
        rd(8'h00, 8'h05, 2'b00);
        stop_test();
    end

    // Watchdog well beyond the expected run of a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
